// file: hw/gpio_cfg_pkg.sv
// package: indices, reset values and types for the port pin configuration subregisters
package gpio_cfg_pkg;

	// subregister indices written to the port index register
	localparam logic [7:0] IDX_HIGH_DRIVE  = 8'h04;
	localparam logic [7:0] IDX_STOP_WAKE   = 8'h05;
	localparam logic [7:0] IDX_PULLUP      = 8'h06;
	localparam logic [7:0] IDX_ALT_SEL_ONE = 8'h07;
	localparam logic [7:0] IDX_ALT_SEL_TWO = 8'h08;

	// reset values
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam logic [7:0] RST_PULLUP_ABC  = 8'h00;
	localparam logic [7:0] RST_PULLUP_D    = 8'h01;
	localparam logic [7:0] RST_PIN8_PORT_A = 8'h04;
	localparam logic [7:0] RST_INDEX       = 8'h00;
	localparam logic [7:0] RST_GPIO_MODE   = 8'hff;
	localparam logic [2:0] RST_SYNC_FILL   = 3'h0;

	// which port this instance serves
	typedef enum logic [1:0]
	{
		PORT_A = 2'b00,
		PORT_B = 2'b01,
		PORT_C = 2'b10,
		PORT_D = 2'b11
	} port_id_t;

	// package variant
	typedef enum logic [1:0]
	{
		PKG_PIN8  = 2'b00,
		PKG_PIN20 = 2'b01,
		PKG_PIN28 = 2'b10
	} pkg_variant_t;

endpackage : gpio_cfg_pkg

// file: hw/gpio_pin_config_subregs.sv
// pin configuration subregisters 04H..08H of one 8-bit general purpose port
//
// Functional notes
// - index 04H routes control register accesses to the high drive enable subregister.
// - high drive bit 1 selects high output current, 0 standard current.
// - high drive acts on the pin driver, also under alternate functions.
// - index 05H routes control register accesses to the stop wake source subregister.
// - in stop mode any edge on a wake-enabled pin starts recovery.
// - pins with wake source bit 0 never start recovery.
// - index 06H routes control register accesses to the pull-up enable subregister.
// - pull-up bit 1 switches the weak pull-up on, 0 off.
// - pull-up resets to 00H ports A-C, 01H port D, 04H 8-pin port A.
// - index 07H routes control register accesses to the first alternate set subregister.
// - set-1 bit matters only while the pin's alternate function enable is set.
// - index 08H routes control register accesses to the second alternate set subregister.
// - set-2 resets to 00H, except 04H on 8-pin port A.
// - set-2 selection also takes effect only with alternate function enabled.
// - enabled pin combines set-1 and set-2 bits into one of four functions.
// - pin without alternate enable is plain GPIO, selectors ignored.
module gpio_pin_config_subregs
	import gpio_cfg_pkg::*;
#(
	parameter port_id_t     PORT_ID = PORT_A,
	parameter pkg_variant_t VARIANT = PKG_PIN28
)
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       index_wr,
	input  wire logic       index_rd,
	input  wire logic       ctl_wr,
	input  wire logic       ctl_rd,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata_q,
	input  wire logic [7:0] pin_in,
	input  wire logic [7:0] alt_func_enable,
	input  wire logic       stop_mode,
	output logic            stop_wake_q,
	output logic      [7:0] high_drive_q,
	output logic      [7:0] pullup_q,
	output logic      [7:0] gpio_mode_q,
	output logic      [7:0] alt_choice_one_q,
	output logic      [7:0] alt_choice_two_q
);

	// reset value of the pull-up subregister for this port and variant
	function automatic logic [7:0] pullup_reset(input port_id_t p, input pkg_variant_t v);
		logic [7:0] r;
		r = RST_PULLUP_ABC;
		if (p == PORT_D)
			r = RST_PULLUP_D;
		if (v == PKG_PIN8 && p == PORT_A)
			r = RST_PIN8_PORT_A;
		return r;
	endfunction : pullup_reset

	// reset value of the second alternate set subregister
	function automatic logic [7:0] alt_two_reset(input port_id_t p, input pkg_variant_t v);
		logic [7:0] r;
		r = RST_ZERO;
		if (v == PKG_PIN8 && p == PORT_A)
			r = RST_PIN8_PORT_A;
		return r;
	endfunction : alt_two_reset

	// subregister read mux; indices owned by other blocks read as zero here
	function automatic logic [7:0] sub_read(
		input logic [7:0] idx,
		input logic [7:0] hde,
		input logic [7:0] smre,
		input logic [7:0] pue,
		input logic [7:0] as1,
		input logic [7:0] as2
	);
		logic [7:0] r;
		r = RST_ZERO;
		unique case (idx)
			IDX_HIGH_DRIVE:  r = hde;
			IDX_STOP_WAKE:   r = smre;
			IDX_PULLUP:      r = pue;
			IDX_ALT_SEL_ONE: r = as1;
			IDX_ALT_SEL_TWO: r = as2;
			default:         r = RST_ZERO;
		endcase
		return r;
	endfunction : sub_read

	// true for the indices this block owns; the rest belong to other subregister blocks
	function automatic logic is_owned(input logic [7:0] idx);
		return (idx >= IDX_HIGH_DRIVE) && (idx <= IDX_ALT_SEL_TWO);
	endfunction : is_owned

	localparam logic [7:0] RST_PULLUP  = pullup_reset(PORT_ID, VARIANT);
	localparam logic [7:0] RST_ALT_TWO = alt_two_reset(PORT_ID, VARIANT);

	logic [7:0] index_q;
	logic [7:0] index_d;
	logic [7:0] high_drive_sub_q;
	logic [7:0] high_drive_sub_d;
	logic [7:0] stop_wake_sub_q;
	logic [7:0] stop_wake_sub_d;
	logic [7:0] pullup_sub_q;
	logic [7:0] pullup_sub_d;
	logic [7:0] alt_one_sub_q;
	logic [7:0] alt_one_sub_d;
	logic [7:0] alt_two_sub_q;
	logic [7:0] alt_two_sub_d;
	logic [7:0] rdata_d;

	// register file: index register and the five subregisters
	always_comb
	begin
		index_d          = index_q;
		high_drive_sub_d = high_drive_sub_q;
		stop_wake_sub_d  = stop_wake_sub_q;
		pullup_sub_d     = pullup_sub_q;
		alt_one_sub_d    = alt_one_sub_q;
		alt_two_sub_d    = alt_two_sub_q;
		rdata_d          = rdata_q;
		if (index_wr)
			index_d = wdata;
		// a control write lands only in the subregister the index names
		if (ctl_wr)
		begin
			unique case (index_q)
				IDX_HIGH_DRIVE:  high_drive_sub_d = wdata;
				IDX_STOP_WAKE:   stop_wake_sub_d  = wdata;
				IDX_PULLUP:      pullup_sub_d     = wdata;
				IDX_ALT_SEL_ONE: alt_one_sub_d    = wdata;
				IDX_ALT_SEL_TWO: alt_two_sub_d    = wdata;
				default:         high_drive_sub_d = high_drive_sub_q; // other blocks own it
			endcase
		end
		// read data holds until the next read strobe
		if (index_rd)
			rdata_d = index_q;
		else if (ctl_rd)
			rdata_d = sub_read(index_q, high_drive_sub_q, stop_wake_sub_q,
				pullup_sub_q, alt_one_sub_q, alt_two_sub_q);
	end

	// register file flops; reset values per port and variant
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			index_q          <= RST_INDEX;
			high_drive_sub_q <= RST_ZERO;
			stop_wake_sub_q  <= RST_ZERO;
			pullup_sub_q     <= RST_PULLUP;
			alt_one_sub_q    <= RST_ZERO;
			alt_two_sub_q    <= RST_ALT_TWO;
			rdata_q          <= RST_ZERO;
		end
		else
		begin
			index_q          <= index_d;
			high_drive_sub_q <= high_drive_sub_d;
			stop_wake_sub_q  <= stop_wake_sub_d;
			pullup_sub_q     <= pullup_sub_d;
			alt_one_sub_q    <= alt_one_sub_d;
			alt_two_sub_q    <= alt_two_sub_d;
			rdata_q          <= rdata_d;
		end
	end

	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;
	logic [7:0] pin_prev_q;
	logic [7:0] pin_meta_d;
	logic [7:0] pin_sync_d;
	logic [7:0] pin_prev_d;
	logic       stop_wake_d;
	logic [2:0] sync_fill_q;
	logic [2:0] sync_fill_d;

	// pin synchroniser and stop-mode wake detection; edges seen after two flops
	always_comb
	begin
		pin_meta_d  = pin_in;
		pin_sync_d  = pin_meta_q;
		pin_prev_d  = pin_sync_q;
		// edges count only once all three pin flops hold real samples; their reset
		// zeros would otherwise look like an edge on every pin that idles high
		sync_fill_d = {sync_fill_q[1:0], 1'b1};
		// both edge directions count; disabled pins are masked out
		stop_wake_d = stop_mode && sync_fill_q[2]
			&& |((pin_sync_q ^ pin_prev_q) & stop_wake_sub_q);
	end

	// synchroniser flops
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_meta_q  <= RST_ZERO;
			pin_sync_q  <= RST_ZERO;
			pin_prev_q  <= RST_ZERO;
			sync_fill_q <= RST_SYNC_FILL;
			stop_wake_q <= 1'b0;
		end
		else
		begin
			pin_meta_q  <= pin_meta_d;
			pin_sync_q  <= pin_sync_d;
			pin_prev_q  <= pin_prev_d;
			sync_fill_q <= sync_fill_d;
			stop_wake_q <= stop_wake_d;
		end
	end

	logic [7:0] high_drive_d;
	logic [7:0] pullup_d;
	logic [7:0] gpio_mode_d;
	logic [7:0] alt_choice_one_d;
	logic [7:0] alt_choice_two_d;

	// pad controls; high drive is not gated by alternate enable since it sits at the driver
	always_comb
	begin
		high_drive_d     = high_drive_sub_q;
		pullup_d         = pullup_sub_q;
		gpio_mode_d      = ~alt_func_enable;
		alt_choice_one_d = alt_one_sub_q & alt_func_enable;
		alt_choice_two_d = alt_two_sub_q & alt_func_enable;
	end

	// pad control flops; they follow the subregisters and the alternate enable one cycle later
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			high_drive_q     <= RST_ZERO;
			pullup_q         <= RST_PULLUP;
			gpio_mode_q      <= RST_GPIO_MODE;
			alt_choice_one_q <= RST_ZERO;
			alt_choice_two_q <= RST_ZERO;
		end
		else
		begin
			high_drive_q     <= high_drive_d;
			pullup_q         <= pullup_d;
			gpio_mode_q      <= gpio_mode_d;
			alt_choice_one_q <= alt_choice_one_d;
			alt_choice_two_q <= alt_choice_two_d;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// write through index 04H reaches the pad two edges later
	a_high_drive_path: assert property (
		(ctl_wr && index_q == IDX_HIGH_DRIVE && !index_wr) ##1 !ctl_wr
		|=> high_drive_q == $past(wdata, 2))
		else $error("high drive write did not reach the pad");

	// high drive follows subregister regardless of alternate enable
	a_high_drive_raw: assert property (
		high_drive_q == $past(high_drive_sub_q))
		else $error("high drive gated or stale");

	// wake subregister write
	a_wake_sub_write: assert property (
		ctl_wr && index_q == IDX_STOP_WAKE |=> stop_wake_sub_q == $past(wdata))
		else $error("wake source write lost");

	// an enabled edge in stop mode raises wake on the next edge, once the pin flops are filled
	a_wake_on_edge: assert property (
		stop_mode && sync_fill_q[2] && |((pin_sync_q ^ pin_prev_q) & stop_wake_sub_q)
		|=> stop_wake_q)
		else $error("enabled edge did not wake");

	// no wake without an enabled edge in stop mode
	a_wake_has_cause: assert property (
		stop_wake_q |-> $past(stop_mode) && ($past(pin_sync_q ^ pin_prev_q)
		& $past(stop_wake_sub_q)) != 8'h00)
		else $error("wake without enabled edge");

	// pull-up write then pad output
	a_pullup_path: assert property (
		ctl_wr && index_q == IDX_PULLUP |=> pullup_sub_q == $past(wdata)
		##1 pullup_q == $past(wdata, 2))
		else $error("pull-up write did not reach the pad");

	// alternate set writes land in their own subregister only
	a_alt_one_write: assert property (
		ctl_wr && index_q == IDX_ALT_SEL_ONE |=> alt_one_sub_q == $past(wdata)
		&& alt_two_sub_q == $past(alt_two_sub_q))
		else $error("set-1 write wrong");

	a_alt_two_write: assert property (
		ctl_wr && index_q == IDX_ALT_SEL_TWO |=> alt_two_sub_q == $past(wdata)
		&& alt_one_sub_q == $past(alt_one_sub_q))
		else $error("set-2 write wrong");

	// disabled pins are GPIO with selectors masked
	a_alt_gating: assert property (
		((gpio_mode_q & (alt_choice_one_q | alt_choice_two_q)) == 8'h00)
		&& gpio_mode_q == ~$past(alt_func_enable))
		else $error("selector leaks on GPIO pin");

	// choice combines both set bits for enabled pins
	a_alt_choice: assert property (
		alt_choice_two_q == ($past(alt_two_sub_q) & $past(alt_func_enable))
		&& alt_choice_one_q == ($past(alt_one_sub_q) & $past(alt_func_enable)))
		else $error("alternate choice mismatch");

	// control read at index 06H returns the pull-up subregister
	a_ctl_read: assert property (
		ctl_rd && !index_rd && index_q == IDX_PULLUP |=> rdata_q == $past(pullup_sub_q))
		else $error("control read wrong");

	// pull-up pad output follows its subregister one edge later
	a_pullup_raw: assert property (
		pullup_q == $past(pullup_sub_q))
		else $error("pull-up pad output stale");

	// wake stays quiet outside stop mode
	a_wake_idle: assert property (
		!stop_mode |=> !stop_wake_q)
		else $error("wake raised outside stop mode");

	// an index write lands in the index register
	a_index_write: assert property (
		index_wr |=> index_q == $past(wdata))
		else $error("index write lost");

	// index read returns the index register
	a_index_read: assert property (
		index_rd |=> rdata_q == $past(index_q))
		else $error("index read wrong");

	// read data stands until the next read strobe
	a_rdata_hold: assert property (
		!ctl_rd && !index_rd |=> $stable(rdata_q))
		else $error("read data changed without a read");

	// a control write to an index owned elsewhere leaves all five subregisters alone
	a_unmapped_write: assert property (
		ctl_wr && !is_owned(index_q) |=> $stable(high_drive_sub_q)
		&& $stable(stop_wake_sub_q) && $stable(pullup_sub_q)
		&& $stable(alt_one_sub_q) && $stable(alt_two_sub_q))
		else $error("unowned index write changed a subregister");

	// control reads of indices owned elsewhere give zero
	a_unmapped_read: assert property (
		ctl_rd && !index_rd && !is_owned(index_q) |=> rdata_q == RST_ZERO)
		else $error("unowned index read not zero");

endmodule : gpio_pin_config_subregs

// file: tb/pin_far_side.sv
// far-side model: external circuits holding levels on the eight port pins
module pin_far_side
(
	output logic [7:0] pin_level
);
	timeunit 1ns;
	timeprecision 1ps;

	// pins start at a fixed pattern so no edge is seen before a test asks for one
	initial pin_level = 8'h55;

	// flips the chosen pins between clock edges, since a pin level is not tied to the core clock
	task automatic flip(input logic [7:0] mask);
		#3;
		pin_level = pin_level ^ mask;
	endtask : flip
endmodule : pin_far_side

// file: tb/tb_gpio_pin_config_subregs.sv
// bench: subregister access, pad outputs and wake detection of one port
module tb_gpio_pin_config_subregs import gpio_cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       index_wr = 1'b0;
	logic       index_rd = 1'b0;
	logic       ctl_wr = 1'b0;
	logic       ctl_rd = 1'b0;
	logic       stop_mode = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] alt_func_enable = 8'h00;
	logic [7:0] rdata_q, pin_in, high_drive_q, pullup_q, gpio_mode_q, choice1, choice2;
	logic       stop_wake_q;
	logic [7:0] pulses;
	logic [7:0] wv [5] = '{8'hA5, 8'h81, 8'h3C, 8'h96, 8'h5A};
	logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	int         fails = 0;
	int         checked = 0;
	int         cycles = 0;

	// port D of the 28-pin variant: pull-up resets to 01H
	gpio_pin_config_subregs #(.PORT_ID(PORT_D), .VARIANT(PKG_PIN28)) gpio_pin_config_subregs_i
	(
		.core_clk(core_clk), .resetn(resetn), .index_wr(index_wr), .index_rd(index_rd),
		.ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .wdata(wdata), .rdata_q(rdata_q),
		.pin_in(pin_in), .alt_func_enable(alt_func_enable), .stop_mode(stop_mode),
		.stop_wake_q(stop_wake_q), .high_drive_q(high_drive_q), .pullup_q(pullup_q),
		.gpio_mode_q(gpio_mode_q), .alt_choice_one_q(choice1), .alt_choice_two_q(choice2)
	);

	pin_far_side pin_far_side_i (.pin_level(pin_in));

	always #4 core_clk = ~core_clk;

	// the whole run needs some 125 cycles; a hang is cut well beyond that
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8

	// one strobe for one cycle: 0 index write, 1 control write, 2 control read, 3 index read
	task automatic strobe(input int which, input logic [7:0] v);
		@(posedge core_clk);
		wdata <= v;
		index_wr <= (which == 0);
		ctl_wr <= (which == 1);
		ctl_rd <= (which == 2);
		index_rd <= (which == 3);
		@(posedge core_clk);
		{index_wr, ctl_wr, ctl_rd, index_rd} <= 4'h0;
		#1;
	endtask : strobe

	task automatic rd_ctl(input logic [7:0] idx, input logic [7:0] exp);
		strobe(0, idx);
		strobe(2, 8'h00);
		check8(rdata_q, exp);
	endtask : rd_ctl

	// pad outputs follow a write two cycles after the strobe edge
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	// counts wake pulses over a window longer than the three-cycle detection latency
	task automatic count_wake(input logic [7:0] mask, input logic [7:0] exp);
		pulses = 8'h00;
		pin_far_side_i.flip(mask);
		repeat (8)
		begin
			@(posedge core_clk);
			#1;
			pulses = pulses + {7'h00, stop_wake_q};
		end
		check8(pulses, exp);
	endtask : count_wake

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd_ctl(IDX_HIGH_DRIVE + 8'(i), rv[i]);
		check8(pullup_q, RST_PULLUP_D);
		check8(gpio_mode_q, 8'hFF);
		$display("test reset_values done");
		// all five written first, so a write leaking into the neighbour written before it shows on readback
		for (int i = 0; i < 5; i++)
		begin
			strobe(0, IDX_HIGH_DRIVE + 8'(i));
			strobe(1, wv[i]);
		end
		for (int i = 0; i < 5; i++)
			rd_ctl(IDX_HIGH_DRIVE + 8'(i), wv[i]);
		settle();
		check8(high_drive_q, 8'hA5);
		check8(pullup_q, 8'h3C);
		$display("test write_readback done");
		strobe(0, 8'h09);
		strobe(1, 8'hFF);
		strobe(2, 8'h00);
		check8(rdata_q, 8'h00);
		strobe(3, 8'h00);
		check8(rdata_q, 8'h09);
		rd_ctl(IDX_HIGH_DRIVE, 8'hA5);
		$display("test unmapped_index done");
		check8(choice1, 8'h00);
		check8(choice2, 8'h00);
		@(posedge core_clk);
		alt_func_enable <= 8'h0F;
		settle();
		check8(choice1, 8'h06);
		check8(choice2, 8'h0A);
		check8(gpio_mode_q, 8'hF0);
		check8(high_drive_q, 8'hA5);
		$display("test alt_gating done");
		@(posedge core_clk);
		stop_mode <= 1'b1;
		repeat (4) @(posedge core_clk);
		count_wake(8'h02, 8'h00);
		count_wake(8'h01, 8'h01);
		count_wake(8'h01, 8'h01);
		@(posedge core_clk);
		stop_mode <= 1'b0;
		count_wake(8'h01, 8'h00);
		$display("test stop_wake done");
		tally_and_finish();
	end
endmodule : tb_gpio_pin_config_subregs
